// *** rtl/pllco_pkg.sv ***
package pllco_pkg;

    // ============================================================
    // Register port geometry
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 8;

    // ============================================================
    // Register offsets
    localparam logic [15:0] ADDR_DEN_HI   = 16'h0001;
    localparam logic [15:0] ADDR_DEN_LO   = 16'h0002;
    localparam logic [15:0] ADDR_NUM_HI   = 16'h0003;
    localparam logic [15:0] ADDR_NUM_LO   = 16'h0004;
    localparam logic [15:0] ADDR_MDT      = 16'h0005;
    localparam logic [15:0] ADDR_LOCK     = 16'h0006;
    localparam logic [15:0] ADDR_CLK_SEL  = 16'h0007;
    localparam logic [15:0] ADDR_REG_CTL  = 16'h0008;

    // ============================================================
    // Field positions
    localparam int unsigned MULT_MSB   = 6;
    localparam int unsigned MULT_LSB   = 3;
    localparam int unsigned PDIV_MSB   = 2;
    localparam int unsigned PDIV_LSB   = 1;
    localparam int unsigned TYPE_BIT   = 0;
    localparam int unsigned LOCK_BIT   = 0;
    localparam int unsigned PWRDN_BIT  = 2;

    // ============================================================
    // Reset values and codes
    localparam logic [7:0] RST_BYTE    = 8'h00;
    localparam logic [2:0] RST_CLK_SEL = 3'h0;
    localparam logic [2:0] RST_REG_CTL = 3'h0;
    localparam logic [3:0] MULT_MIN    = 4'h2;
    localparam logic [3:0] MULT_MAX    = 4'h8;
    localparam logic [2:0] FREQ_X2     = 3'h0;
    localparam logic [2:0] FREQ_X1     = 3'h1;
    localparam logic [2:0] FREQ_DIV2   = 3'h2;
    localparam logic [2:0] FREQ_DIV4   = 3'h3;
    localparam logic [2:0] FREQ_DIV8   = 3'h4;
    localparam logic [2:0] FREQ_OFF    = 3'h7;

    // ============================================================
    // Carriers
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pllco_req_s;

    typedef struct packed {
        logic [15:0] den;
        logic [15:0] num;
        logic [3:0]  mult;
        logic        mult_valid;
        logic [2:0]  pre_div;
        logic        fractional;
    } pllco_cfg_s;

endpackage

// *** rtl/pllco_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module pllco_top
    import pllco_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire logic              ce,
    input  wire pllco_pkg::pllco_req_s reg_req,
    output var  logic [7:0]        rdata,
    output var  logic              rvalid,
    input  wire logic              synth_locked_in,
    input  wire logic              main_clock_enable,
    input  wire logic              pin_clock_mode,
    input  wire logic [1:0]        density_output_control,
    input  wire logic              twice_master_clk,
    output var  pllco_pkg::pllco_cfg_s synth_cfg,
    output var  logic              clock_output_pin,
    output var  logic              regulator_power_down,
    output var  logic [1:0]        regulator_voltage_select
);
    import pllco_pkg::*;

    // ============================================================
    // Reset release
    logic [1:0] rst_sync;
    logic       rst_n_int;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n_int = rst_sync[1];

    // ============================================================
    // Functions
    function automatic logic write_ok(input logic [15:0] a, input logic core_en);
        // Synth registers stay writable so setup can precede clock enable
        write_ok = ((a >= ADDR_DEN_HI) && (a <= ADDR_LOCK)) || core_en;
    endfunction

    function automatic logic [2:0] pre_div_of(input logic [1:0] code);
        pre_div_of = {1'b0, code} + 3'h1;
    endfunction

    function automatic logic mult_ok(input logic [3:0] code);
        mult_ok = (code >= MULT_MIN) && (code <= MULT_MAX);
    endfunction

    // ============================================================
    // Register file
    logic [7:0] den_hi, den_lo, num_hi, num_lo, mdt;
    logic [7:0] next_den_hi, next_den_lo, next_num_hi, next_num_lo, next_mdt;
    logic [2:0] clk_sel, next_clk_sel;
    logic [2:0] reg_ctl, next_reg_ctl;
    logic       lock, next_lock;
    logic [7:0] next_rdata;
    logic       next_rvalid;
    pllco_cfg_s next_cfg;
    logic       wr_en;
    logic [3:0] mult_code;

    always_comb begin
        next_den_hi  = den_hi;
        next_den_lo  = den_lo;
        next_num_hi  = num_hi;
        next_num_lo  = num_lo;
        next_mdt     = mdt;
        next_clk_sel = clk_sel;
        next_reg_ctl = reg_ctl;
        next_lock    = synth_locked_in;
        wr_en        = reg_req.wr && write_ok(reg_req.addr, main_clock_enable);
        if (wr_en) begin
            unique case (reg_req.addr)
                ADDR_DEN_HI:  next_den_hi  = reg_req.wdata;
                ADDR_DEN_LO:  next_den_lo  = reg_req.wdata;
                ADDR_NUM_HI:  next_num_hi  = reg_req.wdata;
                ADDR_NUM_LO:  next_num_lo  = reg_req.wdata;
                ADDR_MDT:     next_mdt     = reg_req.wdata;
                ADDR_CLK_SEL: next_clk_sel = reg_req.wdata[2:0];
                ADDR_REG_CTL: next_reg_ctl = reg_req.wdata[2:0];
                default:      next_mdt     = mdt;
            endcase
        end
        next_rvalid = reg_req.rd;
        next_rdata  = rdata;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                ADDR_DEN_HI:  next_rdata = den_hi;
                ADDR_DEN_LO:  next_rdata = den_lo;
                ADDR_NUM_HI:  next_rdata = num_hi;
                ADDR_NUM_LO:  next_rdata = num_lo;
                ADDR_MDT:     next_rdata = {1'b0, mdt[6:0]};
                ADDR_LOCK:    next_rdata = {7'h00, lock};
                ADDR_CLK_SEL: next_rdata = {5'h00, clk_sel};
                ADDR_REG_CTL: next_rdata = {5'h00, reg_ctl};
                default:      next_rdata = 8'h00;
            endcase
        end
        // Settings handed to the synthesizer: ratio is mult + num/den
        mult_code           = next_mdt[MULT_MSB:MULT_LSB];
        next_cfg.den        = {next_den_hi, next_den_lo};
        next_cfg.num        = {next_num_hi, next_num_lo};
        next_cfg.mult_valid = mult_ok(mult_code);
        next_cfg.mult       = mult_ok(mult_code) ? mult_code : 4'h0;
        next_cfg.pre_div    = pre_div_of(next_mdt[PDIV_MSB:PDIV_LSB]);
        next_cfg.fractional = next_mdt[TYPE_BIT];
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            den_hi                   <= RST_BYTE;
            den_lo                   <= RST_BYTE;
            num_hi                   <= RST_BYTE;
            num_lo                   <= RST_BYTE;
            mdt                      <= RST_BYTE;
            clk_sel                  <= RST_CLK_SEL;
            reg_ctl                  <= RST_REG_CTL;
            lock                     <= 1'b0;
            rdata                    <= 8'h00;
            rvalid                   <= 1'b0;
            synth_cfg                <= '0;
            regulator_power_down     <= 1'b0;
            regulator_voltage_select <= 2'b00;
        end else if (ce) begin
            den_hi                   <= next_den_hi;
            den_lo                   <= next_den_lo;
            num_hi                   <= next_num_hi;
            num_lo                   <= next_num_lo;
            mdt                      <= next_mdt;
            clk_sel                  <= next_clk_sel;
            reg_ctl                  <= next_reg_ctl;
            lock                     <= next_lock;
            rdata                    <= next_rdata;
            rvalid                   <= next_rvalid;
            synth_cfg                <= next_cfg;
            regulator_power_down     <= next_reg_ctl[PWRDN_BIT];
            regulator_voltage_select <= next_reg_ctl[1:0];
        end
    end

    // ============================================================
    // Clock output
    // Divided rates come from edges of the doubled master clock;
    // the 200 MHz sampling limits edge jitter to one period
    logic [3:0] div_cnt, next_div_cnt;
    logic       x2_q, next_x2_q;
    logic       next_clk_out;
    logic       sel_level;
    logic       density_on;
    logic       pin_gate;

    always_comb begin
        next_x2_q    = twice_master_clk;
        next_div_cnt = (twice_master_clk && !x2_q) ? div_cnt + 4'h1 : div_cnt;
        unique case (clk_sel)
            FREQ_X2:   sel_level = x2_q;
            FREQ_X1:   sel_level = div_cnt[0];
            FREQ_DIV2: sel_level = div_cnt[1];
            FREQ_DIV4: sel_level = div_cnt[2];
            FREQ_DIV8: sel_level = div_cnt[3];
            default:   sel_level = 1'b0;
        endcase
        density_on   = |density_output_control;
        pin_gate     = pin_clock_mode &&
                       !(density_on && (clk_sel <= FREQ_X1));
        next_clk_out = pin_gate && sel_level;
    end

    always_ff @(posedge clk or negedge rst_n_int) begin
        if (!rst_n_int) begin
            div_cnt          <= 4'h0;
            x2_q             <= 1'b0;
            clock_output_pin <= 1'b0;
        end else if (ce) begin
            div_cnt          <= next_div_cnt;
            x2_q             <= next_x2_q;
            clock_output_pin <= next_clk_out;
        end
    end

    // ============================================================
    // Checks
    logic [7:0] req_wdata;
    assign req_wdata = reg_req.wdata;

    sequence s_wr_at(logic [15:0] a);
        ce && reg_req.wr && (reg_req.addr == a) && write_ok(a, main_clock_enable);
    endsequence

    sequence s_locked_then_read;
        (ce && synth_locked_in) ##1 (ce && reg_req.rd && (reg_req.addr == ADDR_LOCK));
    endsequence

    sequence s_off_two;
        (ce && (clk_sel == FREQ_OFF))[*2];
    endsequence

    property p_den_write;
        @(posedge clk) disable iff (!rst_n_int)
        s_wr_at(ADDR_DEN_HI) |=> (synth_cfg.den[15:8] == $past(req_wdata));
    endproperty
    a_den_write: assert property (p_den_write)
        else $error("denominator high byte not taken");

    property p_num_write;
        @(posedge clk) disable iff (!rst_n_int)
        s_wr_at(ADDR_NUM_LO) |=> (synth_cfg.num[7:0] == $past(req_wdata));
    endproperty
    a_num_write: assert property (p_num_write)
        else $error("numerator low byte not taken");

    property p_mult_type;
        @(posedge clk) disable iff (!rst_n_int)
        s_wr_at(ADDR_MDT) |=> (synth_cfg.fractional == $past(req_wdata[0]))
            && (synth_cfg.mult_valid == mult_ok($past(req_wdata[6:3])));
    endproperty
    a_mult_type: assert property (p_mult_type)
        else $error("multiplier or type field wrong");

    property p_pre_div;
        @(posedge clk) disable iff (!rst_n_int)
        s_wr_at(ADDR_MDT) |=> (synth_cfg.pre_div == pre_div_of($past(req_wdata[2:1])));
    endproperty
    a_pre_div: assert property (p_pre_div)
        else $error("pre-divider ratio wrong");

    property p_lock_read;
        @(posedge clk) disable iff (!rst_n_int)
        s_locked_then_read |=> rvalid && (rdata == 8'h01);
    endproperty
    a_lock_read: assert property (p_lock_read)
        else $error("lock flag not reported");

    property p_off_low;
        @(posedge clk) disable iff (!rst_n_int)
        s_off_two |=> !clock_output_pin;
    endproperty
    a_off_low: assert property (p_off_low)
        else $error("clock output not held low when off");

    property p_pin_mode;
        @(posedge clk) disable iff (!rst_n_int)
        (ce && !pin_clock_mode) |=> !clock_output_pin;
    endproperty
    a_pin_mode: assert property (p_pin_mode)
        else $error("clock output active outside clock mode");

    property p_density_block;
        @(posedge clk) disable iff (!rst_n_int)
        (ce && (density_output_control != 2'b00) && (clk_sel <= FREQ_X1)) |=> !clock_output_pin;
    endproperty
    a_density_block: assert property (p_density_block)
        else $error("fast rate present with density output on");

    property p_regulator;
        @(posedge clk) disable iff (!rst_n_int)
        s_wr_at(ADDR_REG_CTL) |=> (regulator_power_down == $past(req_wdata[2]))
            && (regulator_voltage_select == $past(req_wdata[1:0]));
    endproperty
    a_regulator: assert property (p_regulator)
        else $error("regulator control not applied");

    property p_write_blocked;
        @(posedge clk) disable iff (!rst_n_int)
        (ce && reg_req.wr && (reg_req.addr == ADDR_REG_CTL) && !main_clock_enable)
            |=> $stable(regulator_voltage_select) && $stable(regulator_power_down);
    endproperty
    a_write_blocked: assert property (p_write_blocked)
        else $error("regulator written while main clock off");

endmodule

`default_nettype wire

// *** tb/pllco_partner.sv ***
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Reference clock source and synthesizer lock
module pllco_partner (
    input  wire logic lock_req,
    output var  logic twice_master_clk,
    output var  logic synth_locked_in
);
    // Twice the 12.288 MHz master, free running
    initial begin
        twice_master_clk = 1'b0;
        forever #20.345 twice_master_clk = ~twice_master_clk;
    end

    // Lock settles slowly, drops at once; one process owns the flag
    initial begin
        synth_locked_in = 1'b0;
        forever begin
            @(lock_req);
            if (lock_req) begin
                #50 synth_locked_in = 1'b1;
            end else begin
                synth_locked_in = 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb;
    import pllco_pkg::*;
    logic       clk, rstn, ce, lock_req, locked, mce, pin_mode, x2, pin, pd;
    logic [1:0] dens, vsel;
    logic [7:0] rdata;
    logic       rvalid;
    pllco_req_s req;
    pllco_cfg_s cfg;
    int         fail_count, checked;

    pllco_top u_dut (.clk(clk), .rstn(rstn), .ce(ce), .reg_req(req), .rdata(rdata),
        .rvalid(rvalid), .synth_locked_in(locked), .main_clock_enable(mce),
        .pin_clock_mode(pin_mode), .density_output_control(dens), .twice_master_clk(x2),
        .synth_cfg(cfg), .clock_output_pin(pin), .regulator_power_down(pd),
        .regulator_voltage_select(vsel));
    pllco_partner u_partner (.lock_req(lock_req), .twice_master_clk(x2),
        .synth_locked_in(locked));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ============================================================
    // Shared tasks
    task automatic stop_test();
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        int n;
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd = 1'b0;
        n = 0;
        while (rvalid !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        if (n == 4) begin
            fail_count++;
            $display("ERROR %0t read never answered", $time);
            stop_test();
        end else begin
            chk(16'(rdata), 16'(exp), what);
        end
    endtask

    // Rises of the pin against rises of the reference over one window
    task automatic t_out(input logic mode, input logic [1:0] dn, input logic [2:0] code,
                         input int sh);
        int np, nr, d;
        logic pp, pr;
        pin_mode = mode;
        dens = dn;
        wr(ADDR_CLK_SEL, {5'h00, code});
        repeat (4) @(negedge clk);
        np = 0;
        nr = 0;
        pp = pin;
        pr = x2;
        repeat (400) begin
            @(negedge clk);
            np += int'(pin && !pp);
            nr += int'(x2 && !pr);
            pp = pin;
            pr = x2;
        end
        d = (sh < 0) ? np : np - (nr >> sh);
        chk(16'(d >= -2 && d <= 2), 16'h0001, "output rate");
        if (sh < 0) chk(16'(pin), 16'h0000, "output held low");
        $display("test output code %0d mode %0d density %0d done", code, mode, dn);
    endtask

    // ============================================================
    // Scenarios
    task automatic t_reset();
        for (int a = 1; a <= 8; a++) rd(16'(a), 8'h00, "reset value");
        chk(16'(cfg.pre_div), 16'h0001, "pre-divide after reset");
        chk(16'({pd, vsel}), 16'h0000, "regulator after reset");
        $display("test reset done");
    endtask

    task automatic t_synth();
        logic [7:0] v;
        wr(ADDR_DEN_HI, 8'ha5);
        wr(ADDR_DEN_LO, 8'h3c);
        wr(ADDR_NUM_HI, 8'h12);
        wr(ADDR_NUM_LO, 8'hef);
        chk(cfg.den, 16'ha53c, "denominator");
        chk(cfg.num, 16'h12ef, "numerator");
        rd(ADDR_DEN_LO, 8'h3c, "den low readback");
        rd(ADDR_NUM_HI, 8'h12, "num high readback");
        for (int c = 0; c <= 8; c++) begin
            v = {1'b0, 4'(c), 2'(c % 4), 1'(c % 2)};
            wr(ADDR_MDT, v);
            chk(16'(cfg.mult), (c >= 2) ? 16'(c) : 16'h0000, "multiplier");
            chk(16'(cfg.mult_valid), 16'(c >= 2), "multiplier valid");
            chk(16'(cfg.pre_div), 16'(c % 4 + 1), "pre-divide");
            chk(16'(cfg.fractional), 16'(c % 2), "type");
            rd(ADDR_MDT, v, "integer setting readback");
        end
        $display("test synth done");
    endtask

    task automatic t_lock();
        rd(ADDR_LOCK, 8'h00, "unlocked");
        lock_req = 1'b1;
        repeat (20) @(negedge clk);
        rd(ADDR_LOCK, 8'h01, "locked");
        wr(ADDR_LOCK, 8'hfe);
        rd(ADDR_LOCK, 8'h01, "lock flag write ignored");
        lock_req = 1'b0;
        repeat (4) @(negedge clk);
        rd(ADDR_LOCK, 8'h00, "lock dropped");
        $display("test lock done");
    endtask

    task automatic t_regs();
        mce = 1'b0;
        wr(ADDR_REG_CTL, 8'h07);
        wr(ADDR_CLK_SEL, 8'h03);
        chk(16'(pd), 16'h0000, "regulator write refused");
        rd(ADDR_CLK_SEL, 8'h00, "rate write refused");
        lock_req = 1'b1;
        repeat (20) @(negedge clk);
        mce = 1'b1;
        wr(ADDR_REG_CTL, 8'h07);
        chk(16'({pd, vsel}), 16'h0007, "power down, reserved code");
        rd(ADDR_REG_CTL, 8'h07, "regulator readback");
        wr(ADDR_REG_CTL, 8'h01);
        chk(16'({pd, vsel}), 16'h0001, "active at 1.1 V");
        wr(16'h0009, 8'hff);
        rd(16'h0009, 8'h00, "unmapped read");
        rd(16'h0000, 8'h00, "unmapped low read");
        $display("test registers done");
    endtask

    task automatic t_freeze();
        ce = 1'b0;
        wr(ADDR_NUM_HI, 8'h5a);
        chk(cfg.num, 16'h12ef, "write held off by clock enable");
        ce = 1'b1;
        wr(ADDR_NUM_HI, 8'h5a);
        chk(cfg.num, 16'h5aef, "write after clock enable");
        $display("test clock enable done");
    endtask

    // ============================================================
    // Main sequence
    initial begin
        fail_count = 0;
        checked = 0;
        rstn = 1'b0;
        ce = 1'b1;
        lock_req = 1'b0;
        mce = 1'b0;
        pin_mode = 1'b0;
        dens = 2'h0;
        req = '0;
        repeat (3) @(negedge clk);
        rstn = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_synth();
        t_lock();
        t_regs();
        t_freeze();
        for (int c = 0; c <= 4; c++) t_out(1'b1, 2'h0, 3'(c), c);
        t_out(1'b1, 2'h0, 3'h7, -1);
        t_out(1'b1, 2'h0, 3'h5, -1);
        t_out(1'b0, 2'h0, 3'h2, -1);
        t_out(1'b1, 2'h1, 3'h0, -1);
        t_out(1'b1, 2'h2, 3'h1, -1);
        t_out(1'b1, 2'h3, 3'h2, 2);
        stop_test();
    end
endmodule

`default_nettype wire
